// *** rtl/etd_top.sv ***
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// - setting tx_enable_bit moves the transmitter from off to idle, awaiting DMA.
// - a DMA request makes the MAC frame the data and drive it onto MII.
// - half duplex: wait for no carrier, then one interframe gap, then preamble.
// - full duplex: no carrier sensing, preamble starts right after the request.
// - full duplex back-to-back frames keep an interframe gap after the previous one.
// - preamble, then start delimiter, then data, then CRC, always in that order.
// - a fully sent frame raises the frame_sent_event flag.
// - collision and lost carrier during a frame each raise their own flag.
// - after a frame the MAC idles and starts pending data without software.
// - two DMA channels, transmit and receive, each with its own request and list; only the transmit channel has an engine here.
// - buffer data is fetched in bursts of 16 bytes.
// - the transmit buffer is reachable only by the DMA engine, never by software.
// - writing 1 to tx_request_bit starts descriptor fetching by the engine.
// - a descriptor is read first; its length and address drive the transfer.
// - after its last byte is taken, the descriptor is written back: valid cleared; a frame-end descriptor waits for the frame and stores status.
// - fetching begins at tx_list_start_addr written by software.
// - descriptors are contiguous at the stride given by the descriptor length field.
// - words: control and status, buffer length, buffer address, then padding.
// - the descriptor length setting fixes the padding after the three words.
// - one frame in one buffer, or gathered from several consecutive descriptors.
// - frame position bit0 low means continues, bit0 high means frame end.
// - an invalid descriptor clears tx_request_bit and stops transmission.
// - a new request resumes at the descriptor after the last transmitted.
// - the request is taken only while tx_enable_bit is 1.
module etd_top
  import etd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // system bus master
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic             mem_burst_out,
  output logic      [31:0] mem_addr_out,
  output logic      [31:0] mem_wdata_out,
  input  wire logic        mem_ack_in,
  input  wire logic [31:0] mem_rdata_in,
  // mii transmit side
  input  wire logic        mii_tx_clk_in,
  input  wire logic        mii_crs_in,
  input  wire logic        mii_col_in,
  output logic             mii_tx_en_out,
  output logic      [3:0]  mii_txd_out,
  // event output
  output logic             irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // ==========================================================
  // pin synchronisers
  logic [2:0]      pin_in;
  logic [2:0]      s1_ff;
  logic [2:0]      s2_ff;
  logic [2:0]      s3_ff;
  logic [2:0]      lvl_ff;
  logic            tick;
  logic            crs;
  logic            col;

  assign pin_in = {mii_col_in, mii_crs_in, mii_tx_clk_in};
  // three stages; a level changes only once stages two and three agree
  for (genvar gi = 0; gi < 3; gi++) begin : g_sync
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        s1_ff[gi]  <= 1'h0;
        s2_ff[gi]  <= 1'h0;
        s3_ff[gi]  <= 1'h0;
        lvl_ff[gi] <= 1'h0;
      end else begin
        s1_ff[gi] <= pin_in[gi];
        s2_ff[gi] <= s1_ff[gi];
        s3_ff[gi] <= s2_ff[gi];
        if (s2_ff[gi] == s3_ff[gi]) begin
          lvl_ff[gi] <= s3_ff[gi];
        end
      end
    end
  end
  assign tick = s2_ff[0] & s3_ff[0] & ~lvl_ff[0];
  assign crs  = lvl_ff[1];
  assign col  = lvl_ff[2];

  // ==========================================================
  // software registers
  logic            txen_ff;
  logic            fdx_ff;
  logic [1:0]      dl_ff;
  logic            tx_req_ff;
  logic            rx_req_ff;
  logic [31:0]     tx_list_ff;
  logic [31:0]     rx_list_ff;
  logic [NEVT-1:0] evt_ff;
  logic [NEVT-1:0] mask_ff;
  logic [NEVT-1:0] evt_set;
  logic [31:0]     rdata_ff;
  logic            dma_stop;
  logic            req_wr;
  etd_dma_t        dst_ff;
  etd_mac_t        mst_ff;

  assign req_wr = reg_wr_in && reg_addr_in == REG_TX_REQ && reg_wdata_in[REQ_BIT];

  // plain configuration registers; the rx list only holds the receive channel setup
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      txen_ff    <= 1'h0;
      fdx_ff     <= 1'h0;
      dl_ff      <= 2'h0;
      tx_list_ff <= '0;
      rx_list_ff <= '0;
      mask_ff    <= '0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        REG_MAC_MODE: begin
          txen_ff <= reg_wdata_in[MM_TXEN];
          fdx_ff  <= reg_wdata_in[MM_FDX];
        end
        REG_DMA_MODE: dl_ff <= reg_wdata_in[1:0];
        REG_TX_LIST:  tx_list_ff <= reg_wdata_in;
        REG_RX_LIST:  rx_list_ff <= reg_wdata_in;
        REG_MASK:     mask_ff <= reg_wdata_in[NEVT-1:0];
        default: ;
      endcase
    end
  end

  // request bits; a software set beats the engine's own clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_req_ff <= 1'h0;
      rx_req_ff <= 1'h0;
    end else begin
      if (req_wr && txen_ff) begin
        tx_req_ff <= 1'h1;
      end else if (dma_stop) begin
        tx_req_ff <= 1'h0;
      end
      if (reg_wr_in && reg_addr_in == REG_RX_REQ) begin
        rx_req_ff <= reg_wdata_in[REQ_BIT];
      end
    end
  end

  // sticky events, write one to clear, set wins over clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      evt_ff <= '0;
    end else if (reg_wr_in && reg_addr_in == REG_EVT) begin
      evt_ff <= (evt_ff & ~reg_wdata_in[NEVT-1:0]) | evt_set;
    end else begin
      evt_ff <= evt_ff | evt_set;
    end
  end
  assign irq_out = |(evt_ff & mask_ff);

  // read port; the transmit buffer has no address here at all
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= '0;
      if (reg_rd_in) begin
        case (reg_addr_in)
          REG_MAC_MODE: rdata_ff <= 32'({fdx_ff, txen_ff});
          REG_DMA_MODE: rdata_ff <= 32'(dl_ff);
          REG_TX_REQ:   rdata_ff <= 32'(tx_req_ff);
          REG_RX_REQ:   rdata_ff <= 32'(rx_req_ff);
          REG_TX_LIST:  rdata_ff <= tx_list_ff;
          REG_RX_LIST:  rdata_ff <= rx_list_ff;
          REG_EVT:      rdata_ff <= 32'(evt_ff);
          REG_MASK:     rdata_ff <= 32'(mask_ff);
          REG_STATE:    rdata_ff <= 32'({1'h0, mst_ff, 1'h0, dst_ff});
          default:      rdata_ff <= '0;
        endcase
      end
    end
  end
  assign reg_rdata_out = rdata_ff;

  // ==========================================================
  // transmit dma engine
  logic [31:0]     cur_ff;
  logic [31:0]     ctl_ff;
  logic [LEN_W-1:0] rem_ff;
  logic [1:0]      beat_ff;
  logic [3:0]      idx_ff;
  logic [31:0]     maddr_ff;
  logic [31:0]     mwdata_ff;
  logic [31:0]     blk_ff [4];
  logic [31:0]     stride;
  logic [31:0]     wb_word;
  logic            tx_valid;
  logic            tx_last;
  logic [7:0]      tx_byte;
  logic            byte_take;
  logic            done_ff;
  logic            col_fr_ff;
  logic            crs_fr_ff;

  assign stride   = DESC_BASE << dl_ff;
  assign dma_stop = dst_ff == D_RD0 && mem_ack_in && !mem_rdata_in[D0_VALID];
  // end-of-frame descriptors carry the link result, others keep their status
  assign wb_word  = ctl_ff[D0_FP_END] ?
                    {1'h0, ctl_ff[30:2], crs_fr_ff, col_fr_ff} : {1'h0, ctl_ff[30:0]};
  assign tx_valid = dst_ff == D_FEED;
  assign tx_last  = tx_valid && ctl_ff[D0_FP_END] && rem_ff == 16'h1;
  assign tx_byte  = blk_ff[idx_ff[3:2]][8*idx_ff[1:0] +: 8];

  // descriptor walk; a 16-byte block is fetched only after the previous one drains
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dst_ff   <= D_IDLE;
      cur_ff   <= '0;
      ctl_ff   <= '0;
      rem_ff   <= '0;
      beat_ff  <= 2'h0;
      idx_ff   <= 4'h0;
      maddr_ff <= '0;
      for (int i = 0; i < 4; i++) begin
        blk_ff[i] <= '0;
      end
    end else begin
      unique case (dst_ff)
        D_IDLE: if (tx_req_ff) begin
          maddr_ff <= cur_ff;
          dst_ff   <= D_RD0;
        end
        D_RD0: if (mem_ack_in) begin
          ctl_ff <= mem_rdata_in;
          if (mem_rdata_in[D0_VALID]) begin
            maddr_ff <= cur_ff + W1_OFS;
            dst_ff   <= D_RD1;
          end else begin
            dst_ff <= D_IDLE;
          end
        end
        D_RD1: if (mem_ack_in) begin
          rem_ff   <= mem_rdata_in[LEN_W-1:0];
          maddr_ff <= cur_ff + W2_OFS;
          dst_ff   <= D_RD2;
        end
        D_RD2: if (mem_ack_in) begin
          if (rem_ff == '0) begin
            maddr_ff <= cur_ff;
            dst_ff   <= D_WB;
          end else begin
            maddr_ff <= mem_rdata_in;
            beat_ff  <= 2'h0;
            dst_ff   <= D_BURST;
          end
        end
        D_BURST: if (mem_ack_in) begin
          blk_ff[beat_ff] <= mem_rdata_in;
          beat_ff         <= beat_ff + 2'h1;
          maddr_ff        <= maddr_ff + WORD_BYTES;
          if (beat_ff == LAST_BEAT) begin
            idx_ff <= 4'h0;
            dst_ff <= D_FEED;
          end
        end
        D_FEED: if (byte_take) begin
          rem_ff <= rem_ff - 16'h1;
          idx_ff <= idx_ff + 4'h1;
          if (rem_ff == 16'h1) begin
            if (ctl_ff[D0_FP_END]) begin
              dst_ff <= D_WAITTX;
            end else begin
              maddr_ff <= cur_ff;
              dst_ff   <= D_WB;
            end
          end else if (idx_ff == LAST_IDX) begin
            beat_ff <= 2'h0;
            dst_ff  <= D_BURST;
          end
        end
        D_WAITTX: if (done_ff) begin
          maddr_ff <= cur_ff;
          dst_ff   <= D_WB;
        end
        D_WB: if (mem_ack_in) begin
          cur_ff <= ctl_ff[D0_LEND] ? tx_list_ff : cur_ff + stride;
          dst_ff <= D_IDLE;
        end
      endcase
      if (dst_ff == D_IDLE && reg_wr_in && reg_addr_in == REG_TX_LIST) begin
        cur_ff <= reg_wdata_in;
      end
    end
  end

  // write-back word registered so the bus sees only flip-flop data
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mwdata_ff <= '0;
    end else begin
      mwdata_ff <= wb_word;
    end
  end
  assign mem_req_out   = dst_ff != D_IDLE && dst_ff != D_FEED && dst_ff != D_WAITTX;
  assign mem_we_out    = dst_ff == D_WB;
  assign mem_burst_out = dst_ff == D_BURST;
  assign mem_addr_out  = maddr_ff;
  assign mem_wdata_out = mwdata_ff;

  // ==========================================================
  // mac transmitter
  logic            mtx_en_ff;
  logic [3:0]      txd_ff;
  logic [3:0]      cnt_ff;
  logic            hi_ff;
  logic [3:0]      hold_ff;
  logic            last_ff;
  logic [31:0]     crc_ff;
  logic [4:0]      ifg_ff;
  logic            ifg_done;
  logic            go;
  logic            crs_lost;

  function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  assign ifg_done  = ifg_ff == IFG_NIB;
  assign go        = ifg_done && (fdx_ff || !crs);
  assign byte_take = tick && mst_ff == M_DATA && !hi_ff && tx_valid;

  // frame sequencer; every link nibble changes on a rising link clock
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mst_ff    <= M_OFF;
      mtx_en_ff <= 1'h0;
      txd_ff    <= 4'h0;
      cnt_ff    <= 4'h0;
      hi_ff     <= 1'h0;
      hold_ff   <= 4'h0;
      last_ff   <= 1'h0;
      crc_ff    <= CRC_INIT;
      done_ff   <= 1'h0;
    end else begin
      done_ff <= 1'h0;
      if (!txen_ff) begin
        mst_ff    <= M_OFF;
        mtx_en_ff <= 1'h0;
      end else begin
        unique case (mst_ff)
          M_OFF: mst_ff <= M_IDLE;
          M_IDLE, M_DEFER: if (tx_valid) begin
            if (go) begin
              mst_ff <= M_PRE;
              cnt_ff <= 4'h0;
              crc_ff <= CRC_INIT;
            end else begin
              mst_ff <= M_DEFER;
            end
          end
          M_PRE: if (tick) begin
            mtx_en_ff <= 1'h1;
            txd_ff    <= PRE_NIB;
            cnt_ff    <= cnt_ff + 4'h1;
            if (cnt_ff == PRE_LAST) begin
              mst_ff <= M_SFD;
              hi_ff  <= 1'h0;
            end
          end
          M_SFD: if (tick) begin
            txd_ff <= hi_ff ? SFD_NIB : PRE_NIB;
            hi_ff  <= !hi_ff;
            if (hi_ff) begin
              mst_ff <= M_DATA;
            end
          end
          M_DATA: if (tick) begin
            if (!hi_ff) begin
              txd_ff  <= tx_byte[3:0];
              hold_ff <= tx_byte[7:4];
              last_ff <= tx_last;
              crc_ff  <= crc_nib(crc_ff, tx_byte[3:0]);
              hi_ff   <= 1'h1;
            end else begin
              txd_ff <= hold_ff;
              crc_ff <= crc_nib(crc_ff, hold_ff);
              hi_ff  <= 1'h0;
              if (last_ff) begin
                mst_ff <= M_CRC;
                cnt_ff <= 4'h0;
              end
            end
          end
          M_CRC: if (tick) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == CRC_LAST) begin
              mtx_en_ff <= 1'h0;
              mst_ff    <= M_IDLE;
              done_ff   <= 1'h1;
            end else begin
              txd_ff <= ~crc_ff[3:0];
              crc_ff <= {4'h0, crc_ff[31:4]};
            end
          end
          default: mst_ff <= M_OFF;
        endcase
      end
    end
  end
  assign mii_tx_en_out = mtx_en_ff;
  assign mii_txd_out   = txd_ff;

  // gap counter restarts on own frames and, in half duplex, on carrier
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ifg_ff <= IFG_NIB;
    end else if (mtx_en_ff || (!fdx_ff && crs)) begin
      ifg_ff <= 5'h0;
    end else if (tick && !ifg_done) begin
      ifg_ff <= ifg_ff + 5'h1;
    end
  end

  // per-frame link faults, reported in the write-back status
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      col_fr_ff <= 1'h0;
      crs_fr_ff <= 1'h0;
    end else if (mst_ff == M_PRE && !mtx_en_ff) begin
      col_fr_ff <= 1'h0;
      crs_fr_ff <= 1'h0;
    end else if (mtx_en_ff) begin
      col_fr_ff <= col_fr_ff | col;
      crs_fr_ff <= crs_fr_ff | crs_lost;
    end
  end
  // our own carrier comes back through the synchroniser a few clocks late,
  // so carrier is judged only once the preamble state has been left
  assign crs_lost = mtx_en_ff && mst_ff != M_PRE && !fdx_ff && !crs;
  assign evt_set  = {crs_lost, mtx_en_ff && col, done_ff};

  // ==========================================================
  // checks
  sequence s_pre_left;
    mst_ff == M_PRE ##1 mst_ff != M_PRE;
  endsequence
  a_enable_idle: assert property ($rose(txen_ff) |=> mst_ff == M_IDLE)
    else $error("enable did not reach idle");
  a_hdx_carrier: assert property (mst_ff == M_DEFER && !fdx_ff && crs |=> mst_ff != M_PRE)
    else $error("preamble started over carrier");
  a_fdx_start: assert property (mst_ff == M_IDLE && txen_ff && fdx_ff && tx_valid && ifg_done
    |=> mst_ff == M_PRE)
    else $error("full duplex start delayed");
  a_frame_order: assert property (s_pre_left |-> mst_ff == M_SFD || mst_ff == M_OFF)
    else $error("delimiter did not follow preamble");
  a_sent_flag: assert property (done_ff |=> evt_ff[EVT_SENT])
    else $error("sent flag missing");
  a_col_flag: assert property (mtx_en_ff && col |=> evt_ff[EVT_COL])
    else $error("collision flag missing");
  a_block_four: assert property (dst_ff == D_BURST && mem_ack_in && beat_ff == LAST_BEAT
    |=> dst_ff == D_FEED && idx_ff == 4'h0)
    else $error("block not four words");
  a_invalid_stop: assert property (dma_stop && !req_wr |=> !tx_req_ff ##1 dst_ff == D_IDLE)
    else $error("invalid descriptor did not stop");
  a_req_gate: assert property (req_wr && !txen_ff && !tx_req_ff |=> !tx_req_ff)
    else $error("request taken while disabled");
  a_ring_wrap: assert property (dst_ff == D_WB && mem_ack_in && ctl_ff[D0_LEND]
    |=> cur_ff == $past(tx_list_ff))
    else $error("ring did not wrap");
  a_flag_sticky: assert property (evt_ff[EVT_SENT] && !(reg_wr_in && reg_addr_in == REG_EVT)
    |=> evt_ff[EVT_SENT])
    else $error("flag lost without clear");
endmodule

// *** inc/etd_pkg.sv ***
package etd_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0]  REG_MAC_MODE = 8'h00;
  localparam logic [7:0]  REG_DMA_MODE = 8'h04;
  localparam logic [7:0]  REG_TX_REQ   = 8'h08;
  localparam logic [7:0]  REG_RX_REQ   = 8'h0c;
  localparam logic [7:0]  REG_TX_LIST  = 8'h10;
  localparam logic [7:0]  REG_RX_LIST  = 8'h14;
  localparam logic [7:0]  REG_EVT      = 8'h18;
  localparam logic [7:0]  REG_MASK     = 8'h1c;
  localparam logic [7:0]  REG_STATE    = 8'h20;
  // ==========================================================
  // register fields
  localparam int          MM_TXEN      = 0;
  localparam int          MM_FDX       = 1;
  localparam int          REQ_BIT      = 0;
  localparam int          EVT_SENT     = 0;
  localparam int          EVT_COL      = 1;
  localparam int          EVT_CRS      = 2;
  localparam int          NEVT         = 3;
  // ==========================================================
  // descriptor layout
  localparam int          D0_VALID     = 31;
  localparam int          D0_LEND      = 30;
  localparam int          D0_FP_END    = 28;
  localparam int          LEN_W        = 16;
  localparam logic [31:0] W1_OFS       = 32'h4;
  localparam logic [31:0] W2_OFS       = 32'h8;
  localparam logic [31:0] WORD_BYTES   = 32'h4;
  localparam logic [31:0] DESC_BASE    = 32'h10;
  localparam logic [1:0]  LAST_BEAT    = 2'h3;
  localparam logic [3:0]  LAST_IDX     = 4'hf;
  // ==========================================================
  // frame timing in link nibbles
  localparam logic [3:0]  PRE_NIB      = 4'h5;
  localparam logic [3:0]  SFD_NIB      = 4'hd;
  localparam logic [3:0]  PRE_LAST     = 4'hd;
  localparam logic [3:0]  CRC_LAST     = 4'h8;
  localparam logic [4:0]  IFG_NIB      = 5'h18;
  localparam logic [31:0] CRC_POLY     = 32'hedb88320;
  localparam logic [31:0] CRC_INIT     = 32'hffffffff;
  // ==========================================================
  // state machines
  typedef enum logic [2:0] {D_IDLE = 3'b000, D_RD0 = 3'b001, D_RD1 = 3'b010, D_RD2 = 3'b011,
    D_BURST = 3'b100, D_FEED = 3'b101, D_WAITTX = 3'b110, D_WB = 3'b111} etd_dma_t;
  typedef enum logic [2:0] {M_OFF = 3'b000, M_IDLE = 3'b001, M_DEFER = 3'b010, M_PRE = 3'b011,
    M_SFD = 3'b100, M_DATA = 3'b101, M_CRC = 3'b110} etd_mac_t;
endpackage

// *** verif/etd_phy_model.sv ***
`timescale 1ns/1ns
// ==========================================================
// phy transmit side: free link clock, carrier echo, nibble log
module etd_phy_model (
  // mii pins
  input  wire logic       tx_en_in,
  input  wire logic [3:0] txd_in,
  output logic            tx_clk_out,
  output logic            crs_out,
  output logic            col_out,
  // bench controls
  input  wire logic       busy_in,
  input  wire logic       jam_in
);
  logic [3:0] nib [0:255];
  int         cnt     = 0;
  int         idle    = 99;
  int         min_gap = 99;
  logic       en_q    = 1'b0;
  initial tx_clk_out = 1'b0;
  // the phy clocks the link whether or not a frame is on
  always #80 tx_clk_out = ~tx_clk_out;
  // carrier follows our own frame, so only a busy line adds to it
  assign crs_out = busy_in | tx_en_in;
  assign col_out = jam_in & tx_en_in;
  // log nibbles and the shortest idle run between frames
  always @(posedge tx_clk_out) begin
    en_q <= tx_en_in;
    if (tx_en_in) begin
      nib[cnt[7:0]] <= txd_in;
      cnt <= cnt + 1;
      if (!en_q && cnt > 0 && idle < min_gap) min_gap <= idle;
      idle <= 0;
    end else begin
      idle <= idle + 1;
    end
  end
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ns
// ==========================================================
// bench: register master, memory slave, phy model
module tb;
  import etd_pkg::*;
  logic        clk_in       = 1'b0;
  logic        reset_n_in   = 1'b0;
  logic [7:0]  reg_addr_in  = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in    = 1'b0;
  logic        reg_rd_in    = 1'b0;
  logic        mem_ack_in;
  logic [31:0] mem_rdata_in;
  logic        busy         = 1'b0;
  logic        jam          = 1'b0;
  logic [31:0] reg_rdata_out, mem_addr_out, mem_wdata_out;
  logic        mem_req_out, mem_we_out, mem_burst_out, irq_out;
  logic        tx_clk, crs, col, tx_en;
  logic [3:0]  txd;
  logic [31:0] mem [0:255];
  int          fail_count   = 0;
  int          total_checks = 0;
  int          bursts       = 0;
  always #10 clk_in = ~clk_in;
  etd_top dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
    .mem_burst_out(mem_burst_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in),
    .mii_tx_clk_in(tx_clk), .mii_crs_in(crs), .mii_col_in(col), .mii_tx_en_out(tx_en),
    .mii_txd_out(txd), .irq_out(irq_out));
  etd_phy_model phy_u (.tx_en_in(tx_en), .txd_in(txd), .tx_clk_out(tx_clk),
    .crs_out(crs), .col_out(col), .busy_in(busy), .jam_in(jam));
  // memory answers in the cycle of each request; a slower one would let a
  // gathered frame underrun the link between two buffers
  assign mem_ack_in   = mem_req_out;
  assign mem_rdata_in = mem[mem_addr_out[9:2]];
  always @(posedge clk_in) begin
    if (mem_req_out && mem_we_out) mem[mem_addr_out[9:2]] <= mem_wdata_out;
    if (mem_req_out && mem_burst_out) bursts <= bursts + 1;
  end
  // ==========================================================
  // shared tasks
  task automatic summarize();
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  // bounded wait on a register field; running out ends the run
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    for (int i = 0; i < 3000; i++) begin
      rd(a, d);
      if ((d & m) === e) return;
    end
    fail_count++;
    $display("[ERR] poll %h expected %h seen %h", a, e, d);
    summarize();
  endtask
  // descriptor i sits at list start 0x100 plus i times a 16 byte stride
  task automatic sd(input int i, input logic [31:0] w0, input logic [31:0] n,
                    input logic [31:0] ba);
    mem[64+4*i] = w0;
    mem[65+4*i] = n;
    mem[66+4*i] = ba;
  endtask
  task automatic frame_chk(input int b, input int n, input logic [63:0] v);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 16; i++) chk("preamble", (i == 15) ? 32'hd : 32'h5, 32'(phy_u.nib[b+i]));
    for (int i = 0; i < 2 * n; i++) begin
      chk("data", 32'(v[4*i +: 4]), 32'(phy_u.nib[b+16+i]));
      for (int k = 0; k < 4; k++) c = (c[0] ^ v[4*i+k]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    // the check sequence goes out inverted, low nibble first
    for (int i = 0; i < 8; i++) begin
      chk("crc", {28'h0, ~c[4*i +: 4]}, 32'(phy_u.nib[b+16+2*n+i]));
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    rd(REG_STATE, d);
    chk("state", 32'h0, d);
    rd(8'h24, d);
    chk("unmapped", 32'h0, d);
    wr(REG_TX_REQ, 32'h1);
    rd(REG_TX_REQ, d);
    chk("req no enable", 32'h0, d);
    wr(REG_RX_REQ, 32'h1);
    rd(REG_RX_REQ, d);
    chk("rx req", 32'h1, d);
    wr(REG_MASK, 32'h7);
    rd(REG_MASK, d);
    chk("mask", 32'h7, d);
  endtask
  // full duplex: one whole frame, then one gathered from two buffers; the last
  // descriptor ends the list, so the walk wraps to the already written-back first
  task automatic t_full();
    logic [31:0] d;
    sd(0, 32'h90000000, 32'h4, 32'h200);
    sd(1, 32'h80000000, 32'h4, 32'h240);
    sd(2, 32'hd0000000, 32'h4, 32'h280);
    mem[8'h80] = 32'ha1b2c3d4;
    mem[8'h90] = 32'h4b5a6978;
    mem[8'ha0] = 32'h0f1e2d3c;
    wr(REG_MAC_MODE, 32'h3);
    wr(REG_DMA_MODE, 32'h0);
    wr(REG_TX_LIST, 32'h100);
    wr(REG_TX_REQ, 32'h1);
    poll(REG_TX_REQ, 32'h1, 32'h0);
    chk("nibbles", 32'd72, 32'(phy_u.cnt));
    frame_chk(0, 4, {32'h0, 32'ha1b2c3d4});
    frame_chk(32, 8, {32'h0f1e2d3c, 32'h4b5a6978});
    chk("gap", 32'h1, 32'(phy_u.min_gap >= 24));
    chk("wb0", 32'h10000000, mem[8'h40]);
    chk("wb1", 32'h0, mem[8'h44]);
    chk("wb2", 32'h50000000, mem[8'h48]);
    chk("burst words", 32'd12, 32'(bursts));
    rd(REG_EVT, d);
    chk("events", 32'h1, d);
    chk("irq", 32'h1, 32'(irq_out));
    wr(REG_EVT, 32'h1);
    rd(REG_EVT, d);
    chk("events", 32'h0, d);
    chk("irq", 32'h0, 32'(irq_out));
  endtask
  // half duplex: defer on a busy line, resume after the stop, collide
  task automatic t_half();
    logic [31:0] d;
    sd(0, 32'h90000000, 32'h4, 32'h2c0);
    mem[8'hb0] = 32'h5a6b7c8d;
    busy <= 1'b1;
    wr(REG_MAC_MODE, 32'h1);
    wr(REG_TX_REQ, 32'h1);
    repeat (300) @(posedge clk_in);
    chk("deferred", 32'd72, 32'(phy_u.cnt));
    busy <= 1'b0;
    jam  <= 1'b1;
    poll(REG_TX_REQ, 32'h1, 32'h0);
    rd(REG_EVT, d);
    chk("events", 32'h3, d);
    chk("nibbles", 32'd104, 32'(phy_u.cnt));
    frame_chk(72, 4, {32'h0, 32'h5a6b7c8d});
    chk("wb3", 32'h10000001, mem[8'h40]);
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 32'h0;
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    t_regs();
    t_full();
    t_half();
    summarize();
  end
endmodule
